// *** nvm_access_control_register.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Memory space select one targets program flash, zero targets data EEPROM.
// - Config space select chooses configuration registers or flash/EEPROM space.
// - Write abort flag sets when master-clear or watchdog reset cuts a write.
// - Write abort flag clears when a write runs to completion.
// - Write start is set-only by software, starts timed write, hardware clears.
// - Software cannot clear read or write start; hardware clears on finish.
// - Writes start only while write permit set; permit clear after power-up.
// - Write done flag sets on completion and stays until software clears.
module nvm_access_control_register
  import nvm_ctl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES,
  parameter int unsigned TIMER_W_P      = TIMER_W
)
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              master_clear_reset,
  input  wire logic              watchdog_reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output var  logic [DATA_W-1:0] wb_dat_o,
  output var  logic              wb_ack_o,
  output var  logic              target_flash,
  output var  logic              target_config,
  output var  logic              row_erase,
  output var  logic              write_start,
  output var  logic              read_start,
  output var  logic              write_busy,
  output var  logic              irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [REG_W-1:0] pack_ctl(
    input logic mem_sel,
    input logic cfg_sel,
    input logic erase,
    input logic abort,
    input logic permit,
    input logic wr,
    input logic rd
  );
    logic [REG_W-1:0] v;
    v                = '0;
    v[MEM_SEL_BIT]   = mem_sel;
    v[CFG_SEL_BIT]   = cfg_sel;
    v[UNIMP_BIT]     = 1'b0;
    v[ROW_ERASE_BIT] = erase;
    v[ABORT_BIT]     = abort;
    v[PERMIT_BIT]    = permit;
    v[WR_BIT]        = wr;
    v[RD_BIT]        = rd;
    return v;
  endfunction : pack_ctl

  function automatic logic index_hit(
    input logic [ADDR_W-1:0]  adr,
    input logic [INDEX_W-1:0] index
  );
    return adr[ADDR_W-1:2] == index;
  endfunction : index_hit

  // ****************************************
  // State
  // ****************************************
  logic             mem_sel_q;
  logic             mem_sel_d;
  logic             cfg_sel_q;
  logic             cfg_sel_d;
  logic             erase_q;
  logic             erase_d;
  logic             abort_q;
  logic             abort_d;
  logic             permit_q;
  logic             permit_d;
  logic             wr_q;
  logic             wr_d;
  logic             rd_q;
  logic             rd_d;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic             wstart_q;
  logic             wstart_d;
  logic             rstart_q;
  logic             rstart_d;
  logic             irq_q;
  logic             irq_d;
  logic             ack_q;
  logic             ack_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic             sys_reset;
  logic             timer_busy;
  logic             timer_done;
  logic             bus_req;
  logic             bus_wr;
  logic             ctl_wr;
  logic             stat_wr;
  logic             mask_wr;
  logic [REG_W-1:0] wbyte;
  logic             write_cut;

  assign sys_reset = master_clear_reset | watchdog_reset;
  assign write_cut = sys_reset & (timer_busy | (wr_q & ~timer_done));
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign bus_wr    = bus_req & wb_we_i & ack_q & wb_sel_i[0];
  assign wbyte     = wb_dat_i[REG_W-1:0];
  assign ctl_wr    = bus_wr & index_hit(wb_adr_i, CTL_INDEX);
  assign stat_wr   = bus_wr & index_hit(wb_adr_i, IRQ_STAT_INDEX);
  assign mask_wr   = bus_wr & index_hit(wb_adr_i, IRQ_MASK_INDEX);

  // ****************************************
  // Self-timed write engine
  // ****************************************
  nvm_write_timer #(
    .CNT_W  (TIMER_W_P),
    .CYCLES (WRITE_CYCLES_P)
  ) u_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (wstart_q),
    .abort    (sys_reset),
    .busy     (timer_busy),
    .done     (timer_done)
  );

  // ****************************************
  // Control register next state
  // ****************************************
  always_comb
  begin
    mem_sel_d = mem_sel_q;
    cfg_sel_d = cfg_sel_q;
    erase_d   = erase_q;
    abort_d   = abort_q;
    permit_d  = permit_q;
    wr_d      = wr_q;
    rd_d      = rd_q;
    wstart_d  = 1'b0;
    rstart_d  = 1'b0;
    if (rstart_q)
    begin
      rd_d = 1'b0;
    end
    if (ctl_wr && !wr_q && !timer_busy)
    begin
      mem_sel_d = wbyte[MEM_SEL_BIT];
      cfg_sel_d = wbyte[CFG_SEL_BIT];
      erase_d   = wbyte[ROW_ERASE_BIT];
      abort_d   = wbyte[ABORT_BIT];
      permit_d  = wbyte[PERMIT_BIT];
      if (wbyte[WR_BIT] && permit_q)
      begin
        wr_d     = 1'b1;
        wstart_d = 1'b1;
      end
      if (wbyte[RD_BIT] && !rd_q)
      begin
        rd_d     = 1'b1;
        rstart_d = 1'b1;
      end
    end
    if (timer_done)
    begin
      wr_d    = 1'b0;
      abort_d = 1'b0;
      erase_d = 1'b0;
    end
    if (sys_reset)
    begin
      if (write_cut)
      begin
        abort_d = 1'b1;
      end
      permit_d = 1'b0;
      wr_d     = 1'b0;
      rd_d     = 1'b0;
      wstart_d = 1'b0;
      rstart_d = 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask next state
  // ****************************************
  always_comb
  begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (stat_wr)
    begin
      stat_d = stat_q & ~wbyte[IRQ_W-1:0];
    end
    if (mask_wr)
    begin
      mask_d = wbyte[IRQ_W-1:0];
    end
    if (timer_done)
    begin
      stat_d[IRQ_DONE_BIT] = 1'b1;
    end
    if (write_cut)
    begin
      stat_d[IRQ_ABORT_BIT] = 1'b1;
    end
    irq_d = |(stat_q & mask_q);
  end

  // ****************************************
  // Wishbone answer
  // ****************************************
  always_comb
  begin
    ack_d   = bus_req & ~ack_q;
    rdata_d = rdata_q;
    if (bus_req && !ack_q)
    begin
      rdata_d = DATA_RESET;
      if (index_hit(wb_adr_i, CTL_INDEX))
      begin
        rdata_d[REG_W-1:0] = pack_ctl(mem_sel_q, cfg_sel_q, erase_q,
                                      abort_q, permit_q, wr_q, rd_q);
      end
      else if (index_hit(wb_adr_i, IRQ_STAT_INDEX))
      begin
        rdata_d[IRQ_W-1:0] = stat_q;
      end
      else if (index_hit(wb_adr_i, IRQ_MASK_INDEX))
      begin
        rdata_d[IRQ_W-1:0] = mask_q;
      end
      else
      begin
        rdata_d = DATA_RESET;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_sel_q <= CTL_BIT_RESET;
      cfg_sel_q <= CTL_BIT_RESET;
      erase_q   <= CTL_BIT_RESET;
      abort_q   <= CTL_BIT_RESET;
      permit_q  <= CTL_BIT_RESET;
      wr_q      <= CTL_BIT_RESET;
      rd_q      <= CTL_BIT_RESET;
      stat_q    <= IRQ_RESET;
      mask_q    <= IRQ_RESET;
      wstart_q  <= 1'b0;
      rstart_q  <= 1'b0;
      irq_q     <= 1'b0;
      ack_q     <= 1'b0;
      rdata_q   <= DATA_RESET;
    end
    else
    begin
      mem_sel_q <= mem_sel_d;
      cfg_sel_q <= cfg_sel_d;
      erase_q   <= erase_d;
      abort_q   <= abort_d;
      permit_q  <= permit_d;
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      wstart_q  <= wstart_d;
      rstart_q  <= rstart_d;
      irq_q     <= irq_d;
      ack_q     <= ack_d;
      rdata_q   <= rdata_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o      = rdata_q;
  assign wb_ack_o      = ack_q;
  assign target_flash  = mem_sel_q;
  assign target_config = cfg_sel_q;
  assign row_erase     = erase_q;
  assign write_start   = wstart_q;
  assign read_start    = rstart_q;
  assign write_busy    = timer_busy;
  assign irq           = irq_q;

endmodule : nvm_access_control_register
`default_nettype wire

// *** nvm_access_control_register_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvm_access_control_register_chk
  import nvm_ctl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = 20
)
(
  input wire logic              core_clk,
  input wire logic              resetn,
  input wire logic              master_clear_reset,
  input wire logic              watchdog_reset,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0]  wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              target_flash,
  input wire logic              target_config,
  input wire logic              row_erase,
  input wire logic              write_start,
  input wire logic              read_start,
  input wire logic              write_busy,
  input wire logic              irq
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic               ctl_wr;
  logic               sysr;
  logic [TIMER_W-1:0] busy_cnt_q;
  logic [TIMER_W-1:0] busy_cnt_d;

  assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
    && (wb_adr_i[ADDR_W-1:2] == CTL_INDEX);
  assign sysr = master_clear_reset || watchdog_reset;

  always_comb busy_cnt_d = write_busy ? busy_cnt_q + 1'b1 : '0;

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) busy_cnt_q <= '0;
    else busy_cnt_q <= busy_cnt_d;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence ctl_launch;
    ctl_wr ##1 write_start;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  start_cause_a:
    assert property (write_start |-> $past(ctl_wr && wb_dat_i[WR_BIT]))
      else $error("write start without request");
  busy_follow_a:
    assert property (ctl_launch |=> write_busy [*8])
      else $error("busy missing after start");
  busy_max_a:
    assert property (busy_cnt_q <= WRITE_CYCLES_P + 1)
      else $error("write runs too long");
  busy_full_a:
    assert property ($fell(write_busy) && !$past(sysr) && !$past(sysr, 2)
      |-> busy_cnt_q >= WRITE_CYCLES_P - 1) else $error("write too short");
  abort_stop_a:
    assert property (sysr && write_busy |-> ##[1:2] !write_busy)
      else $error("write not aborted");
  pulse_gap_a:
    assert property (sysr |=> !write_start && !read_start)
      else $error("pulse during system reset");
  no_restart_a:
    assert property (write_busy |-> !write_start)
      else $error("start while busy");
  read_once_a:
    assert property (read_start |-> $past(ctl_wr && wb_dat_i[RD_BIT])
      ##1 !read_start) else $error("bad read start");
  flash_sel_a:
    assert property ($changed(target_flash) |-> $past(ctl_wr)
      && target_flash == $past(wb_dat_i[MEM_SEL_BIT]))
      else $error("flash select moved");
  cfg_sel_a:
    assert property ($changed(target_config) |-> $past(ctl_wr)
      && target_config == $past(wb_dat_i[CFG_SEL_BIT]))
      else $error("config select moved");
endmodule : nvm_access_control_register_chk
`default_nettype wire

// *** nvm_ctl_pkg.sv ***
`default_nettype none
package nvm_ctl_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned HZ_PER_MHZ    = 1_000_000;
  localparam int unsigned NS_PER_US     = 1_000;
  localparam int unsigned WRITE_TIME_NS = 4_000_000;
  localparam int unsigned WRITE_CYCLES  =
    (WRITE_TIME_NS / NS_PER_US) * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned TIMER_W       = 18;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned ADDR_W  = 14;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned INDEX_W = 12;
  localparam int unsigned REG_W   = 8;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [INDEX_W-1:0] CTL_INDEX      = 12'hfa6;
  localparam logic [INDEX_W-1:0] IRQ_STAT_INDEX = 12'hfa7;
  localparam logic [INDEX_W-1:0] IRQ_MASK_INDEX = 12'hfa8;

  // ****************************************
  // Control/status field positions
  // ****************************************
  localparam int unsigned MEM_SEL_BIT   = 7;
  localparam int unsigned CFG_SEL_BIT   = 6;
  localparam int unsigned UNIMP_BIT     = 5;
  localparam int unsigned ROW_ERASE_BIT = 4;
  localparam int unsigned ABORT_BIT     = 3;
  localparam int unsigned PERMIT_BIT    = 2;
  localparam int unsigned WR_BIT        = 1;
  localparam int unsigned RD_BIT        = 0;

  // ****************************************
  // Interrupt status and mask layout
  // ****************************************
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_ABORT_BIT = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic             CTL_BIT_RESET = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RESET     = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET   = 32'h0000_0000;

  typedef enum logic [0:0] {
    T_IDLE,
    T_RUN
  } timer_state_e;

endpackage : nvm_ctl_pkg
`default_nettype wire

// *** nvm_write_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvm_write_timer
  import nvm_ctl_pkg::*;
#(
  parameter int unsigned CNT_W  = TIMER_W,
  parameter int unsigned CYCLES = WRITE_CYCLES
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic abort,
  output var  logic busy,
  output var  logic done
);

  timer_state_e     state_q;
  timer_state_e     state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             done_d;
  logic             busy_d;

  // ****************************************
  // Self-timed write sequencing
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    case (state_q)
      T_IDLE:
      begin
        if (start && !abort)
        begin
          state_d = T_RUN;
          cnt_d   = CNT_W'(CYCLES - 1);
        end
      end
      T_RUN:
      begin
        if (abort)
        begin
          state_d = T_IDLE;
        end
        else if (cnt_q == '0)
        begin
          state_d = T_IDLE;
          done_d  = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default:
      begin
        state_d = T_IDLE;
      end
    endcase
    busy_d = (state_d == T_RUN);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= T_IDLE;
      cnt_q   <= '0;
      done    <= 1'b0;
      busy    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done    <= done_d;
      busy    <= busy_d;
    end
  end

endmodule : nvm_write_timer
`default_nettype wire

// *** test_nvm_access_control_register.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_nvm_access_control_register
  import nvm_ctl_pkg::*;
;
  logic              core_clk, resetn, mcr, wdr, cyc, stb, we;
  logic [ADDR_W-1:0] adr;
  logic [SEL_W-1:0]  sel, sel_v;
  logic [DATA_W-1:0] dat, dat_o, r;
  logic              ack, tflash, tcfg, wstart, rstart, busy, irq, rerase;
  int                err_total, checks, ws_n, rs_n, base, n;

  nvm_access_control_register #(.WRITE_CYCLES_P(20), .TIMER_W_P(18)) dut (
    .core_clk(core_clk), .resetn(resetn), .master_clear_reset(mcr),
    .watchdog_reset(wdr), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .target_flash(tflash), .target_config(tcfg),
    .row_erase(rerase), .write_start(wstart), .read_start(rstart),
    .write_busy(busy), .irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (wstart === 1'b1) ws_n++;
    if (rstart === 1'b1) rs_n++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [7:0] exp_ctl(input logic [7:0] w);
    return w & 8'hdc;
  endfunction : exp_ctl

  task automatic xfer(input logic w, input logic [INDEX_W-1:0] idx,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    sel <= sel_v;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) err_total++;
    @(posedge core_clk);
  endtask : xfer

  task automatic wr(input logic [INDEX_W-1:0] idx, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rdchk(input logic [INDEX_W-1:0] idx,
                       input logic [DATA_W-1:0] e, input string nm);
    logic [DATA_W-1:0] q;
    xfer(1'b0, idx, '0, q);
    `CHK(nm, e, q)
  endtask : rdchk

  task tally_and_finish;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    tally_and_finish;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {resetn, mcr, wdr, cyc, stb, we, adr, sel, dat} = '0;
    {err_total, checks, ws_n, rs_n} = '0;
    sel_v = 4'hf;
    r = $urandom(32'hfc23aaf4);
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdchk(CTL_INDEX, 0, "ctl reset");
    rdchk(IRQ_STAT_INDEX, 0, "stat reset");
    for (int i = 0; i < 8; i++)
    begin
      r = (i == 0) ? 32'hffff_fffc : ($urandom & 32'hffff_fffc);
      wr(CTL_INDEX, r);
      rdchk(CTL_INDEX, exp_ctl(r[7:0]), "ctl");
      `CHK("flash", r[7], tflash)
      `CHK("config", r[6], tcfg)
      `CHK("erase", r[4], rerase)
    end
    wr(CTL_INDEX, 0);
    base = ws_n;
    wr(CTL_INDEX, 8'h02);
    wr(CTL_INDEX, 8'h06);
    rdchk(CTL_INDEX, 8'h04, "permit only");
    `CHK("no start", base, ws_n)
    wr(IRQ_MASK_INDEX, 3);
    wr(CTL_INDEX, 8'h0c);
    wr(CTL_INDEX, 8'h0e);
    rdchk(CTL_INDEX, 8'h0e, "wr set");
    `CHK("start", base + 1, ws_n)
    wr(CTL_INDEX, 8'h04);
    rdchk(CTL_INDEX, 8'h0e, "wr held");
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    rdchk(CTL_INDEX, 8'h04, "done ctl");
    rdchk(IRQ_STAT_INDEX, 1, "done flag");
    `CHK("irq", 1'b1, irq)
    rdchk(IRQ_STAT_INDEX, 1, "flag sticks");
    wr(IRQ_STAT_INDEX, 1);
    rdchk(IRQ_STAT_INDEX, 0, "flag clear");
    `CHK("irq off", 1'b0, irq)
    wr(IRQ_MASK_INDEX, 1);
    for (int s = 0; s < 2; s++)
    begin
      wr(CTL_INDEX, 8'h04);
      wr(CTL_INDEX, 8'h06);
      repeat (10) @(posedge core_clk);
      mcr <= (s == 0);
      wdr <= (s == 1);
      repeat (3) @(posedge core_clk);
      mcr <= 1'b0;
      wdr <= 1'b0;
      @(posedge core_clk);
      `CHK("busy abort", 1'b0, busy)
      rdchk(CTL_INDEX, 8'h08, "abort ctl");
      rdchk(IRQ_STAT_INDEX, 2, "abort stat");
      `CHK("irq masked", 1'b0, irq)
      wr(IRQ_STAT_INDEX, 3);
      wr(CTL_INDEX, 0);
    end
    base = rs_n;
    wr(CTL_INDEX, 8'h01);
    rdchk(CTL_INDEX, 0, "rd clear");
    `CHK("read start", base + 1, rs_n)
    sel_v = 4'he;
    wr(CTL_INDEX, 8'hc0);
    sel_v = 4'hf;
    rdchk(CTL_INDEX, 0, "sel ignored");
    `CHK("flash kept", 1'b0, tflash)
    wr(12'h123, $urandom);
    rdchk(12'h123, 0, "unmapped");
    tally_and_finish;
  end
endmodule : test_nvm_access_control_register

bind nvm_access_control_register nvm_access_control_register_chk
  #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) chk (
  .core_clk(core_clk), .resetn(resetn),
  .master_clear_reset(master_clear_reset), .watchdog_reset(watchdog_reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .target_flash(target_flash),
  .target_config(target_config), .row_erase(row_erase),
  .write_start(write_start), .read_start(read_start),
  .write_busy(write_busy), .irq(irq));
`default_nettype wire
